// file: design/pin_sync3.v
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module pin_sync3 #(
	parameter WIDTH = 5
) (
	input wire i_clk, // core clock
	input wire i_rst_n, // synchronised reset, active low
	input wire [WIDTH-1:0] i_pin, // raw pin levels
	input wire [WIDTH-1:0] i_rst_val, // level shown in the first cycle after reset release
	output wire [WIDTH-1:0] o_level // filtered stable level
);
	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;
	reg [WIDTH-1:0] level_r;
	reg rst_done_r;
	genvar g;

	// Reset takes constants only; the idle level is copied at release.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_r <= {WIDTH{1'b0}};
			s2_r <= {WIDTH{1'b0}};
			s3_r <= {WIDTH{1'b0}};
			rst_done_r <= 1'b0;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			rst_done_r <= 1'b1;
		end
	end

	// A change counts only once stages two and three agree.
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : bit_filt
			always @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					level_r[g] <= 1'b0;
				end else if (!rst_done_r) begin
					level_r[g] <= i_rst_val[g];
				end else if (s2_r[g] == s3_r[g]) begin
					level_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	assign o_level = level_r;
endmodule

// file: design/rx_byte_shifter.v
// Serial-to-byte receive shifter.
`timescale 1ns/1ps
`include "spi_frontend_map.vh"
module rx_byte_shifter (
	input wire i_clk, // core clock
	input wire i_rst_n, // synchronised reset, active low
	input wire i_clear, // drop partial byte
	input wire i_shift, // take one bit
	input wire i_bit, // serial bit, msb first
	output reg [7:0] o_byte, // last complete byte
	output reg o_done, // one-cycle pulse per byte
	output wire o_partial // bits held but byte incomplete
);
	reg [6:0] sh_r;
	reg [2:0] cnt_r;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_r <= 7'h00;
			cnt_r <= `RST_BITCNT;
			o_byte <= `RST_BYTE;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_clear) begin
				cnt_r <= `RST_BITCNT;
			end else if (i_shift) begin
				sh_r <= {sh_r[5:0], i_bit};
				cnt_r <= cnt_r + 3'h1;
				if (cnt_r == 3'h7) begin
					o_byte <= {sh_r, i_bit};
					o_done <= 1'b1;
				end
			end
		end
	end

	assign o_partial = (cnt_r != `RST_BITCNT);
endmodule

// file: design/serial_flash_pin_frontend.v
// Pin-level serial front end of a serial flash device.
`timescale 1ns/1ps
`include "spi_frontend_map.vh"
// Overview of operation
// - Select low means active, traffic accepted.
// - Select high deselects and floats output.
// - No command before first select falling edge.
// - Standby only when no internal operation busy.
// - One select frame per operation, registered at release.
// - Input bits sampled on rising serial clock.
// - Output changes after falling serial clock.
// - Single-line read data shifts out one bit per clock.
// - Pause suspends traffic, keeps command context.
// - Paused: output floats, clock and input ignored.
// - Protect low plus disable bit blocks lock writes.
// - Both idle clock levels; rise samples, fall drives.
// - Pause changes only while serial clock low.
// - Quad cache read drives four data lines.
// - Dual cache read drives two data lines.
module serial_flash_pin_frontend (
	input wire I_CORE_CLK, // core clock, 250 MHz
	input wire I_RST_B, // asynchronous reset, active low
	input wire I_CS_B, // chip select pin, active low
	input wire I_SCK, // serial clock pin
	input wire I_SI, // data input pin level (also quad bit 0)
	input wire I_WP_B, // write protect pin level (also quad bit 2)
	input wire I_HOLD_B, // pause pin level (also quad bit 3)
	output reg O_SO, // serial output / quad_data_bit1
	output reg O_SO_OE, // output enable of serial output pin
	output reg O_SI_OUT, // quad_data_bit0 drive
	output reg O_SI_OE, // enable of input pin drive
	output reg O_WP_OUT, // quad_data_bit2 drive
	output reg O_WP_OE, // enable of protect pin drive
	output reg O_HOLD_OUT, // quad_data_bit3 drive
	output reg O_HOLD_OE, // enable of pause pin drive
	output reg [7:0] O_RX_BYTE, // received byte
	output reg O_RX_VALID, // one-cycle pulse, byte received
	output reg O_RX_FIRST, // received byte is the opcode
	output reg O_FRAME_END, // pulse, select released after full bytes
	output reg O_FRAME_ABORT, // pulse, select released mid-byte
	input wire I_TX_EN, // level, core wants read data driven
	input wire [7:0] I_TX_BYTE, // next read byte from core
	output reg O_TX_REQ, // pulse, I_TX_BYTE taken; present next
	input wire I_CORE_BUSY, // program, erase or status write running
	input wire I_LOCK_WR_DIS, // lock_register_write_disable bit
	output reg O_ACTIVE, // device selected and armed
	output reg O_STANDBY, // standby power state
	output reg O_PAUSED, // pause mode in force
	output reg O_LOCK_WR_BLOCK // block-lock bit writes refused
);
	reg rst_m_r;
	reg rst_n_r;
	wire rst_n;
	wire [4:0] pin_level;
	wire cs_st;
	wire sck_st;
	wire si_st;
	wire wp_st;
	wire hold_st;
	reg cs_prev_r;
	reg sck_prev_r;
	reg armed_r;
	reg [2:0] warm_r;
	reg hold_r;
	reg [7:0] opcode_r;
	reg [3:0] bytecnt_r;
	reg tx_on_r;
	reg [1:0] width_r;
	reg [7:0] tx_sh_r;
	reg [3:0] tx_left_r;
	wire cs_fall;
	wire cs_rise;
	wire sck_rise;
	wire sck_fall;
	wire sel;
	wire quad_out;
	wire hold_eff;
	wire [7:0] rx_byte;
	wire rx_done;
	wire rx_partial;
	wire rx_shift;
	wire rx_clear;
	wire tx_want;
	wire [3:0] step;
	reg [7:0] cur_byte;
	reg [3:0] cur_left;

	// Output width selected by the opcode of the frame.
	function [1:0] width_of;
		input [7:0] op;
		begin
			if (op == `OP_READ_CACHE_X4)
				width_of = `WIDTH_X4;
			else if (op == `OP_READ_CACHE_X2)
				width_of = `WIDTH_X2;
			else
				width_of = `WIDTH_X1;
		end
	endfunction

	// Bits consumed per falling clock edge for a width code.
	function [3:0] step_of;
		input [1:0] w;
		begin
			case (w)
				`WIDTH_X2: step_of = 4'h2;
				`WIDTH_X4: step_of = 4'h4;
				default: step_of = 4'h1;
			endcase
		end
	endfunction

	always @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end
	assign rst_n = rst_n_r;

	// Pins idle as deselected, not paused, not protected.
	pin_sync3 #(
		.WIDTH(5)
	) u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_pin({I_HOLD_B, I_WP_B, I_SI, I_SCK, I_CS_B}),
		.i_rst_val(5'h19),
		.o_level(pin_level)
	);
	assign cs_st = pin_level[0];
	assign sck_st = pin_level[1];
	assign si_st = pin_level[2];
	assign wp_st = pin_level[3];
	assign hold_st = pin_level[4];

	assign cs_fall = cs_prev_r & ~cs_st;
	assign cs_rise = ~cs_prev_r & cs_st;
	// Edges are seen through one common delay, so data stays aligned.
	assign sck_rise = ~sck_prev_r & sck_st;
	assign sck_fall = sck_prev_r & ~sck_st;
	assign sel = ~cs_st & armed_r;
	assign quad_out = tx_on_r & (width_r == `WIDTH_X4);
	// The pause pin is our own output in quad reads, never a pause.
	assign hold_eff = hold_r & ~quad_out;
	// Nothing is received while read data is driven, at any width; wide reads own the input pin.
	assign rx_shift = sel & sck_rise & ~hold_eff & ~tx_on_r;
	assign rx_clear = ~sel;

	rx_byte_shifter u_rx (
		.i_clk(I_CORE_CLK),
		.i_rst_n(rst_n),
		.i_clear(rx_clear),
		.i_shift(rx_shift),
		.i_bit(si_st),
		.o_byte(rx_byte),
		.o_done(rx_done),
		.o_partial(rx_partial)
	);

	always @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_r <= 1'b1;
			sck_prev_r <= 1'b0;
			armed_r <= 1'b0;
			warm_r <= 3'h0;
			hold_r <= 1'b0;
		end else begin
			cs_prev_r <= cs_st;
			sck_prev_r <= sck_st;
			if (warm_r != `WARM_CYCLES) begin
				warm_r <= warm_r + 3'h1;
			end
			// Just after reset the synchroniser shows assumed levels, so
			// a select held low would look like a fall; such edges are
			// ignored until the pin copies are real.
			if (cs_fall && (warm_r == `WARM_CYCLES)) begin
				armed_r <= 1'b1;
			end
			// A pause level change only lands while the clock is low,
			// which covers both the direct and the next-fall cases.
			if (cs_st) begin
				hold_r <= 1'b0;
			end else if (!sck_st) begin
				hold_r <= ~hold_st;
			end
		end
	end

	// Opcode and byte position survive a pause; the position is cleared at release.
	always @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			opcode_r <= `RST_BYTE;
			bytecnt_r <= `RST_BYTECNT;
			O_RX_BYTE <= `RST_BYTE;
			O_RX_VALID <= 1'b0;
			O_RX_FIRST <= 1'b0;
			O_FRAME_END <= 1'b0;
			O_FRAME_ABORT <= 1'b0;
		end else begin
			O_RX_VALID <= 1'b0;
			O_FRAME_END <= 1'b0;
			O_FRAME_ABORT <= 1'b0;
			if (!sel) begin
				bytecnt_r <= `RST_BYTECNT;
			end else if (rx_done) begin
				O_RX_BYTE <= rx_byte;
				O_RX_VALID <= 1'b1;
				O_RX_FIRST <= (bytecnt_r == `RST_BYTECNT);
				if (bytecnt_r == `RST_BYTECNT) begin
					opcode_r <= rx_byte;
				end
				if (bytecnt_r != `BYTECNT_MAX) begin
					bytecnt_r <= bytecnt_r + 4'h1;
				end
			end
			// The operation is handed on when the select is released.
			if (cs_rise && armed_r) begin
				O_FRAME_END <= ~rx_partial;
				O_FRAME_ABORT <= rx_partial;
			end
		end
	end

	assign tx_want = sel & I_TX_EN;
	assign step = step_of(width_r);

	// Byte about to be shifted and the bits left in it.
	always @* begin
		cur_byte = tx_sh_r;
		cur_left = tx_left_r;
		if (tx_left_r == 4'h0) begin
			cur_byte = I_TX_BYTE;
			cur_left = `BITS_PER_BYTE;
		end
	end

	always @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tx_on_r <= 1'b0;
			width_r <= `WIDTH_X1;
			tx_sh_r <= `RST_BYTE;
			tx_left_r <= 4'h0;
			O_TX_REQ <= 1'b0;
			O_SO <= 1'b0;
			O_SI_OUT <= 1'b0;
			O_WP_OUT <= 1'b0;
			O_HOLD_OUT <= 1'b0;
		end else begin
			O_TX_REQ <= 1'b0;
			if (!tx_want) begin
				tx_on_r <= 1'b0;
				tx_left_r <= 4'h0;
			end else if (sck_fall && !hold_eff) begin
				// New bits appear only after a falling clock edge, so the
				// host samples them stable at the next rise.
				tx_on_r <= 1'b1;
				width_r <= width_of(opcode_r);
				if (tx_left_r == 4'h0) begin
					O_TX_REQ <= 1'b1;
				end
				case (width_of(opcode_r))
					`WIDTH_X4: begin
						O_HOLD_OUT <= cur_byte[7];
						O_WP_OUT <= cur_byte[6];
						O_SO <= cur_byte[5];
						O_SI_OUT <= cur_byte[4];
						tx_sh_r <= {cur_byte[3:0], 4'h0};
						tx_left_r <= cur_left - 4'h4;
					end
					`WIDTH_X2: begin
						O_SO <= cur_byte[7];
						O_SI_OUT <= cur_byte[6];
						tx_sh_r <= {cur_byte[5:0], 2'h0};
						tx_left_r <= cur_left - 4'h2;
					end
					default: begin
						O_SO <= cur_byte[7];
						tx_sh_r <= {cur_byte[6:0], 1'b0};
						tx_left_r <= cur_left - 4'h1;
					end
				endcase
			end
		end
	end

	// Enables are registered, so pins float one cycle after the cause.
	always @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_SO_OE <= 1'b0;
			O_SI_OE <= 1'b0;
			O_WP_OE <= 1'b0;
			O_HOLD_OE <= 1'b0;
			O_ACTIVE <= 1'b0;
			O_STANDBY <= 1'b0;
			O_PAUSED <= 1'b0;
			O_LOCK_WR_BLOCK <= 1'b0;
		end else begin
			O_SO_OE <= tx_want & tx_on_r & ~hold_eff;
			O_SI_OE <= tx_want & tx_on_r & ~hold_eff & (step != 4'h1);
			O_WP_OE <= tx_want & quad_out;
			O_HOLD_OE <= tx_want & quad_out;
			O_ACTIVE <= sel;
			O_STANDBY <= cs_st & ~I_CORE_BUSY;
			O_PAUSED <= hold_eff & sel;
			// In quad reads the protect pin carries data, not protection.
			O_LOCK_WR_BLOCK <= ~wp_st & I_LOCK_WR_DIS & ~quad_out;
		end
	end
endmodule

// file: design/spi_frontend_map.vh
// Constants of the serial flash pin front end.
`ifndef SPI_FRONTEND_MAP_VH
`define SPI_FRONTEND_MAP_VH

// Opcodes that switch the read data path to several lines.
`define OP_READ_CACHE_X2 8'h3B
`define OP_READ_CACHE_X4 8'h6B

// Output width codes.
`define WIDTH_X1 2'h0
`define WIDTH_X2 2'h1
`define WIDTH_X4 2'h2

// Reset values.
`define RST_BYTE 8'h00
`define RST_BITCNT 3'h0
`define RST_BYTECNT 4'h0

// Bits in one byte and the saturating byte count limit.
`define BITS_PER_BYTE 4'h8
`define BYTECNT_MAX 4'hF

// Core clocks after reset before a select fall may arm the device.
`define WARM_CYCLES 3'h7

`endif

// file: sim/frontend_assertions.sv
// Checker for the serial flash pin front end, bound to its top module.
`timescale 1ns/1ps
module frontend_assertions (
	input wire I_CORE_CLK, // core clock
	input wire I_RST_B, // reset, active low
	input wire I_CS_B, // chip select
	input wire I_SCK, // serial clock
	input wire I_WP_B, // write protect
	input wire I_CORE_BUSY, // internal operation running
	input wire I_LOCK_WR_DIS, // lock write disable
	input wire O_SO, // serial output
	input wire O_SO_OE, // output enables
	input wire O_SI_OE,
	input wire O_WP_OE,
	input wire O_HOLD_OE,
	input wire [7:0] O_RX_BYTE, // received byte
	input wire O_RX_VALID, // byte pulse
	input wire O_RX_FIRST, // opcode flag
	input wire O_FRAME_END, // frame pulses
	input wire O_FRAME_ABORT,
	input wire O_TX_REQ, // read byte taken
	input wire O_ACTIVE, // selected
	input wire O_STANDBY, // standby
	input wire O_PAUSED, // pause in force
	input wire O_LOCK_WR_BLOCK // lock writes refused
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);
	chk_cs_float: assert property (I_CS_B [*8] |=> !(O_SO_OE || O_SI_OE || O_WP_OE || O_HOLD_OE))
		else $error("output driven while deselected");
	chk_busy_standby: assert property (I_CORE_BUSY [*2] |-> !O_STANDBY)
		else $error("standby while busy");
	chk_sel_active: assert property (!I_CS_B [*8] |-> !O_STANDBY)
		else $error("standby while selected");
	chk_lock_set: assert property ((!I_WP_B && I_LOCK_WR_DIS && !O_WP_OE) [*8] |=> O_LOCK_WR_BLOCK)
		else $error("lock writes not refused");
	chk_lock_clear: assert property ((I_WP_B || !I_LOCK_WR_DIS) [*8] |=> !O_LOCK_WR_BLOCK)
		else $error("lock writes refused wrongly");
	chk_pause_float: assert property (O_PAUSED [*3] |-> !O_SO_OE)
		else $error("output driven in pause");
	chk_rx_pulse: assert property (O_RX_VALID |=> !O_RX_VALID)
		else $error("receive pulse too long");
	chk_rx_hold: assert property ($changed(O_RX_BYTE) |-> O_RX_VALID)
		else $error("received byte changed alone");
	chk_frame_pulse: assert property (O_FRAME_END |-> !O_FRAME_ABORT ##1 !O_FRAME_END)
		else $error("frame end malformed");
	chk_so_fall: assert property ((O_SO_OE && $changed(O_SO)) |-> !I_SCK)
		else $error("output changed with clock high");
	chk_tx_active: assert property (O_TX_REQ |-> O_ACTIVE && !O_PAUSED)
		else $error("read byte taken while idle");
	cover property (O_RX_VALID && O_RX_FIRST);
	cover property (O_FRAME_ABORT);
	cover property (O_TX_REQ && O_HOLD_OE);
endmodule

// file: sim/spi_host_model.sv
// Behavioural SPI host driving the flash pins.
`timescale 1ns/1ps
module spi_host_model (
	output logic cs_b, // chip select
	output logic sck, // serial clock
	output logic si, // data to device
	output logic si_oe, // host drives data pin
	output logic wp_b, // write protect
	output logic wp_oe, // host drives protect pin
	output logic hold_b, // pause
	output logic hold_oe, // host drives pause pin
	input wire logic [3:0] dq // pause, protect, output, data lines
);
	localparam int HALF = 32;
	logic cpol = 1'b0;
	initial begin
		cs_b = 1'b0;
		sck = 1'b0;
		{si, wp_b, hold_b} = 3'b011;
		{si_oe, wp_oe, hold_oe} = 3'b111;
	end
	task automatic sel(input logic lvl);
		sck = cpol;
		if (lvl)
			{si_oe, wp_oe, hold_oe} = 3'b111;
		#HALF cs_b = lvl;
		#HALF;
	endtask
	// Both modes: data set after a fall, sampled at the rise.
	task automatic clk1(input logic b, output logic [3:0] q);
		sck = 1'b0;
		si = b;
		#HALF sck = 1'b1;
		q = dq;
		#HALF;
	endtask
	task automatic xbyte(input logic [7:0] d, input int w, output logic [7:0] q);
		logic [3:0] r;
		si_oe = (w == 1);
		hold_oe = (w != 4);
		wp_oe = (w != 4);
		for (int k = 0; k < 8; k += w) begin
			clk1(d[7-k], r);
			q = (w == 1) ? {q[6:0], r[1]} : (w == 2) ? {q[5:0], r[1:0]} : {q[3:0], r};
		end
	endtask
endmodule

// file: sim/testbench.sv
// Top bench: host model, core stand-in and reference queues.
`timescale 1ns/1ps
`include "spi_frontend_map.vh"
module testbench;
	logic I_CORE_CLK = 1'b0;
	logic I_RST_B = 1'b0;
	logic I_TX_EN = 1'b0;
	logic [7:0] I_TX_BYTE = 8'h00;
	logic I_CORE_BUSY = 1'b0;
	logic I_LOCK_WR_DIS = 1'b0;
	logic I_CS_B, I_SCK, I_SI, I_WP_B, I_HOLD_B, O_SO, O_SO_OE, O_SI_OUT;
	logic O_SI_OE, O_WP_OUT, O_WP_OE, O_HOLD_OUT, O_HOLD_OE, O_RX_VALID;
	logic O_RX_FIRST, O_FRAME_END, O_FRAME_ABORT, O_TX_REQ, O_ACTIVE;
	logic O_STANDBY, O_PAUSED, O_LOCK_WR_BLOCK;
	logic [7:0] O_RX_BYTE;
	logic h_si, h_si_oe, h_wp, h_wp_oe, h_hold, h_hold_oe;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_end = 0;
	int n_abort = 0;
	logic [8:0] rxq[$];
	logic [7:0] txq[$];
	logic [7:0] d;
	logic [3:0] r4;
	// A released shared line shows the inverse of its last level.
	assign I_SI = O_SI_OE ? O_SI_OUT : (h_si_oe ? h_si : !h_si);
	assign I_WP_B = O_WP_OE ? O_WP_OUT : (h_wp_oe ? h_wp : !h_wp);
	assign I_HOLD_B = O_HOLD_OE ? O_HOLD_OUT : (h_hold_oe ? h_hold : !h_hold);
	serial_flash_pin_frontend uut (
		.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B),
		.I_SCK(I_SCK), .I_SI(I_SI), .I_WP_B(I_WP_B), .I_HOLD_B(I_HOLD_B),
		.O_SO(O_SO), .O_SO_OE(O_SO_OE), .O_SI_OUT(O_SI_OUT),
		.O_SI_OE(O_SI_OE), .O_WP_OUT(O_WP_OUT), .O_WP_OE(O_WP_OE),
		.O_HOLD_OUT(O_HOLD_OUT), .O_HOLD_OE(O_HOLD_OE),
		.O_RX_BYTE(O_RX_BYTE), .O_RX_VALID(O_RX_VALID),
		.O_RX_FIRST(O_RX_FIRST), .O_FRAME_END(O_FRAME_END),
		.O_FRAME_ABORT(O_FRAME_ABORT), .I_TX_EN(I_TX_EN),
		.I_TX_BYTE(I_TX_BYTE), .O_TX_REQ(O_TX_REQ),
		.I_CORE_BUSY(I_CORE_BUSY), .I_LOCK_WR_DIS(I_LOCK_WR_DIS),
		.O_ACTIVE(O_ACTIVE), .O_STANDBY(O_STANDBY), .O_PAUSED(O_PAUSED),
		.O_LOCK_WR_BLOCK(O_LOCK_WR_BLOCK)
	);
	spi_host_model host (.cs_b(I_CS_B), .sck(I_SCK), .si(h_si), .si_oe(h_si_oe),
		.wp_b(h_wp), .wp_oe(h_wp_oe), .hold_b(h_hold), .hold_oe(h_hold_oe),
		.dq({I_HOLD_B, I_WP_B, O_SO, I_SI}));
	initial forever #2 I_CORE_CLK = ~I_CORE_CLK;
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge I_CORE_CLK);
	endtask
	task automatic put(input logic f, input logic [7:0] b);
		logic [7:0] r;
		rxq.push_back({f, b});
		host.xbyte(b, 1, r);
	endtask
	task automatic frame(input int n);
		int e;
		e = n_end;
		host.sel(1'b0);
		for (int i = 0; i < n; i++)
			put(i == 0, 8'($urandom) | ((i == 0) ? 8'h80 : 8'h00));
		host.sel(1'b1);
		wait_clk(10);
		chk("frame_end", 9'(e + 1), 9'(n_end));
		chk("rx_left", 9'h000, 9'(rxq.size()));
	endtask
	task automatic rd(input int w, input logic [7:0] op);
		logic [7:0] r;
		host.sel(1'b0);
		put(1'b1, op);
		for (int i = 0; i < 3; i++)
			put(1'b0, 8'($urandom));
		@(negedge I_CORE_CLK) I_TX_EN = 1'b1;
		txq.delete();
		for (int i = 0; i < 2; i++) begin
			host.xbyte(8'h00, w, r);
			chk("read_byte", {1'b0, txq.pop_front()}, {1'b0, r});
		end
		chk("lines", {6'h00, 1'b1, w > 1, w == 4}, {6'h00, O_SO_OE, O_SI_OE, O_HOLD_OE & O_WP_OE});
		@(negedge I_CORE_CLK) I_TX_EN = 1'b0;
		host.sel(1'b1);
		wait_clk(4);
		chk("float", 9'h000, {5'h00, O_SO_OE, O_SI_OE, O_WP_OE, O_HOLD_OE});
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(negedge I_CORE_CLK) begin
		if (O_FRAME_END === 1'b1) n_end++;
		if (O_FRAME_ABORT === 1'b1) n_abort++;
		if (O_RX_VALID === 1'b1) begin
			if (rxq.size() == 0) chk("rx_extra", 9'h000, {1'b1, O_RX_BYTE});
			else chk("rx_byte", rxq.pop_front(), {O_RX_FIRST, O_RX_BYTE});
		end
		if (O_TX_REQ === 1'b1) begin
			txq.push_back(I_TX_BYTE);
			I_TX_BYTE <= 8'($urandom);
		end
	end
	initial begin
		#200_000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		int e;
		void'($urandom(32'h806d2e7b));
		I_TX_BYTE = 8'($urandom);
		wait_clk(4);
		I_RST_B = 1'b1;
		wait_clk(8);
		// Select was low since reset, so no falling edge has armed traffic.
		for (int i = 0; i < 8; i++) host.clk1(1'b1, r4);
		host.sel(1'b1);
		wait_clk(4);
		chk("standby", 9'h001, {8'h00, O_STANDBY});
		I_CORE_BUSY = 1'b1;
		wait_clk(4);
		chk("busy_standby", 9'h000, {8'h00, O_STANDBY});
		I_CORE_BUSY = 1'b0;
		frame(3);
		host.sel(1'b0);
		put(1'b1, 8'h9C);
		d = 8'($urandom);
		rxq.push_back({1'b0, d});
		for (int i = 7; i >= 0; i--) begin
			host.clk1(d[i], r4);
			if (i == 4) begin
				host.hold_b = 1'b0;
				repeat (3) host.clk1(!d[i], r4);
				chk("paused", 9'h002, {7'h00, O_PAUSED, O_SO_OE});
				host.hold_b = 1'b1;
			end
		end
		host.sel(1'b1);
		host.sel(1'b0);
		repeat (5) host.clk1(1'b1, r4);
		e = n_abort;
		host.sel(1'b1);
		wait_clk(10);
		chk("abort", 9'(e + 1), 9'(n_abort));
		frame(1);
		host.cpol = 1'b1;
		host.sck = 1'b1;
		frame(3);
		host.cpol = 1'b0;
		host.sck = 1'b0;
		rd(1, 8'h0B);
		rd(2, `OP_READ_CACHE_X2);
		rd(4, `OP_READ_CACHE_X4);
		for (int c = 0; c < 4; c++) begin
			host.wp_b = c[1];
			I_LOCK_WR_DIS = c[0];
			wait_clk(12);
			chk("lock", {8'h00, c == 1}, {8'h00, O_LOCK_WR_BLOCK});
		end
		end_sim;
	end
endmodule
bind serial_flash_pin_frontend frontend_assertions chk_i (
	.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B),
	.I_SCK(I_SCK), .I_WP_B(I_WP_B), .I_CORE_BUSY(I_CORE_BUSY),
	.I_LOCK_WR_DIS(I_LOCK_WR_DIS), .O_SO(O_SO), .O_SO_OE(O_SO_OE),
	.O_SI_OE(O_SI_OE), .O_WP_OE(O_WP_OE), .O_HOLD_OE(O_HOLD_OE),
	.O_RX_BYTE(O_RX_BYTE), .O_RX_VALID(O_RX_VALID),
	.O_RX_FIRST(O_RX_FIRST), .O_FRAME_END(O_FRAME_END),
	.O_FRAME_ABORT(O_FRAME_ABORT), .O_TX_REQ(O_TX_REQ),
	.O_ACTIVE(O_ACTIVE), .O_STANDBY(O_STANDBY), .O_PAUSED(O_PAUSED),
	.O_LOCK_WR_BLOCK(O_LOCK_WR_BLOCK)
);
